/* hw/reset_and_power_mode_control.sv */
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "rpm_consts.svh"
// Operation
// RQ1 - Oscillator is halved; only the halved clock enable drives internal timing.
// RQ2 - Writing one to idle_request_bit enters idle mode.
// RQ3 - In idle, core clock gated; peripheral and interrupt clocks keep running.
// RQ4 - Idle ends on any taken interrupt or on reset.
// RQ5 - Writing one to powerdown_request_bit stops all clocks, oscillator too.
// RQ6 - Power-down ignores interrupts; only reset exits it; here i_rst_n does; the pin only if the timebase stopped at S5P2, where the sampler keeps firing.
// RQ7 - External high reset sampled once per machine cycle at state five phase two.
// RQ8 - Reset source holds input high at least two machine cycles, oscillator running.
// RQ9 - Reset input filtered so short glitches never start a reset.
// RQ10 - Reset loads all port latches with ones.
// RQ11 - Reset loads stack pointer with seven.
// RQ12 - Reset clears power_control_register except bit four.
// RQ13 - Reset clears other special registers except serial_buffer_register.
// RQ14 - power_off_flag set on power-on reset, cleared by software write.
// RQ15 - Machine cycle is twelve oscillator periods: six states of two phases.
module reset_and_power_mode_control
   import rpm_pkg::*;
#(
   parameter int HOLD_MC = `RPM_RST_HOLD_MC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_por,
   input wire logic i_ext_reset,
   input wire logic i_irq,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_core_clk_en,
   output logic o_periph_clk_en,
   output logic o_osc_en,
   output logic o_sys_reset,
   output logic [31:0] o_ports,
   output logic [7:0] o_stack_ptr
);

   // ==========================================================
   // Timebase
   logic div2_r, div2_nxt;
   mc_pos_t pos_r, pos_nxt;
   logic sample_pt;

   // ==========================================================
   // Reset filter and sampling
   logic [1:0] filt_r, filt_nxt;
   logic rst_clean_r, rst_clean_nxt;
   logic [3:0] hold_r, hold_nxt;
   logic sys_rst_r, sys_rst_nxt;

   // ==========================================================
   // Registers
   pm_state_t pm_r, pm_nxt;
   logic [7:0] pwr_ctrl_r, pwr_ctrl_nxt;
   logic [7:0] sp_r, sp_nxt;
   logic [31:0] ports_r, ports_nxt;
   logic [31:0] misc_r, misc_nxt;
   logic [31:0] serial_buf_r, serial_buf_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic pready_r, pready_nxt;
   logic osc_en_r, osc_en_nxt;
   logic core_en_r, core_en_nxt;
   logic per_en_r, per_en_nxt;
   apb_req_t req;
   // Access start opens the answer, the completion edge commits a write
   logic acc_start;
   logic wr_acc, rd_acc, in_reset;

   // Address decode used by the write path; the read path decodes in its own case mux
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   // Bus phase decode: a write takes effect only at the edge that completes the transfer
   assign req = '{paddr: i_paddr, pwrite: i_pwrite, pwdata: i_pwdata};
   assign acc_start = i_psel && i_penable && !pready_r;
   assign wr_acc = i_psel && i_penable && req.pwrite && pready_r;
   assign rd_acc = acc_start && !req.pwrite;

   // Chip reset from either the bench reset or the filtered external pin
   assign in_reset = sys_rst_r || !i_rst_n;

   // One strobe per machine cycle, at the second phase of the fifth state
   assign sample_pt = div2_r && (pos_r.state == `RPM_SAMPLE_STATE) && (pos_r.phase == `RPM_SAMPLE_PHASE);

   // ==========================================================
   // Timebase process
   // Divide-by-two clock: one halved period is one state, its two halves the phases
   // Twelve oscillator clocks make a machine cycle; all of it freezes while the oscillator is off
   always_comb begin
      div2_nxt = div2_r;
      pos_nxt = pos_r;
      if (osc_en_r) begin
         div2_nxt = !div2_r; // [RQ1]
         pos_nxt.phase = !div2_r; // [RQ15]
         if (div2_r) begin
            pos_nxt.state = (pos_r.state == 3'd5) ? 3'd0 : pos_r.state + 3'd1; // [RQ15]
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         div2_r <= 1'b0;
         pos_r <= '0;
      end else begin
         div2_r <= div2_nxt;
         pos_r <= pos_nxt;
      end
   end

   // ==========================================================
   // Reset pin processes
   // Glitch filter, S5P2 sampler and hold counter over machine cycles
   always_comb begin
      filt_nxt = {filt_r[0], i_ext_reset};
      rst_clean_nxt = rst_clean_r;
      if (filt_r == 2'b11) begin
         rst_clean_nxt = 1'b1; // [RQ9]
      end else if (filt_r == 2'b00) begin
         rst_clean_nxt = 1'b0; // [RQ9]
      end
      // Count high samples; the first low sample releases the reset
      hold_nxt = hold_r;
      sys_rst_nxt = sys_rst_r;
      if (sample_pt) begin
         if (rst_clean_r) begin // [RQ7]
            if (hold_r < 4'(HOLD_MC)) begin
               hold_nxt = hold_r + 4'd1;
            end
            if (hold_r + 4'd1 >= 4'(HOLD_MC)) begin
               sys_rst_nxt = 1'b1; // [RQ8]
            end
         end else begin
            hold_nxt = 4'd0;
            sys_rst_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         filt_r <= 2'b00;
         rst_clean_r <= 1'b0;
         hold_r <= 4'd0;
         sys_rst_r <= 1'b0;
      end else begin
         filt_r <= filt_nxt;
         rst_clean_r <= rst_clean_nxt;
         hold_r <= hold_nxt;
         sys_rst_r <= sys_rst_nxt;
      end
   end

   // ==========================================================
   // Power mode processes
   // Power mode sequencer and clock gating
   always_comb begin
      pm_nxt = pm_r;
      case (pm_r)
         PM_RUN: begin
            if (pwr_ctrl_r[`RPM_BIT_PDOWN]) begin
               pm_nxt = PM_PDOWN; // [RQ5]
            end else if (pwr_ctrl_r[`RPM_BIT_IDLE]) begin
               pm_nxt = PM_IDLE; // [RQ2]
            end
         end
         PM_IDLE: begin
            if (i_irq) begin
               pm_nxt = PM_RUN; // [RQ4]
            end
         end
         PM_PDOWN: begin
            pm_nxt = PM_PDOWN; // [RQ6]
         end
         default: pm_nxt = PM_RUN;
      endcase
      if (in_reset) begin
         pm_nxt = PM_RUN; // [RQ4] [RQ6]
      end
      osc_en_nxt = (pm_nxt != PM_PDOWN); // [RQ5]
      core_en_nxt = (pm_nxt == PM_RUN); // [RQ3]
      per_en_nxt = (pm_nxt != PM_PDOWN); // [RQ3]
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pm_r <= PM_RUN;
         osc_en_r <= 1'b1;
         core_en_r <= 1'b1;
         per_en_r <= 1'b1;
      end else begin
         pm_r <= pm_nxt;
         osc_en_r <= osc_en_nxt;
         core_en_r <= core_en_nxt;
         per_en_r <= per_en_nxt;
      end
   end

   // ==========================================================
   // Register file
   // Bus writes, reset loads, mode bits clear on exit
   always_comb begin
      pwr_ctrl_nxt = pwr_ctrl_r;
      sp_nxt = sp_r;
      ports_nxt = ports_r;
      misc_nxt = misc_r;
      serial_buf_nxt = serial_buf_r;
      // Software writes land at the completion edge of the transfer
      if (wr_acc) begin
         if (hit(req.paddr, `RPM_OFF_PWR_CTRL)) begin
            pwr_ctrl_nxt = req.pwdata[7:0]; // [RQ2] [RQ5] [RQ14]
         end
         if (hit(req.paddr, `RPM_OFF_STACK_PTR)) begin
            sp_nxt = req.pwdata[7:0];
         end
         if (hit(req.paddr, `RPM_OFF_PORTS)) begin
            ports_nxt = req.pwdata;
         end
         if (hit(req.paddr, `RPM_OFF_SFR_MISC)) begin
            misc_nxt = req.pwdata;
         end
         if (hit(req.paddr, `RPM_OFF_SERIAL_BUF)) begin
            serial_buf_nxt = req.pwdata;
         end
      end
      // Idle request bit clears itself on wake
      if (pm_r == PM_IDLE && pm_nxt == PM_RUN) begin
         pwr_ctrl_nxt[`RPM_BIT_IDLE] = 1'b0;
      end
      // Reset loads; the power-off flag and the serial buffer keep their contents
      if (in_reset) begin
         pwr_ctrl_nxt = {3'b000, pwr_ctrl_r[`RPM_BIT_POWER_OFF_FLAG], 4'h0}; // [RQ12]
         sp_nxt = `RPM_RST_SP; // [RQ11]
         ports_nxt = `RPM_RST_PORTS; // [RQ10]
         misc_nxt = 32'h00000000; // [RQ13]
         serial_buf_nxt = serial_buf_r; // [RQ13]
      end
      // Power-on indication wins over a software clear
      if (i_por) begin
         pwr_ctrl_nxt[`RPM_BIT_POWER_OFF_FLAG] = 1'b1; // [RQ14]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      pwr_ctrl_r <= pwr_ctrl_nxt;
      sp_r <= sp_nxt;
      ports_r <= ports_nxt;
      misc_r <= misc_nxt;
      serial_buf_r <= serial_buf_nxt;
   end

   // ==========================================================
   // Bus answer
   // APB read mux and one-wait-state answer, formed at the first access edge
   always_comb begin
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      pready_nxt = acc_start;
      if (acc_start) begin
         prdata_nxt = 32'h00000000;
         case (req.paddr)
            `RPM_OFF_PWR_CTRL: prdata_nxt = {24'h000000, pwr_ctrl_r};
            `RPM_OFF_STACK_PTR: prdata_nxt = {24'h000000, sp_r};
            `RPM_OFF_PORTS: prdata_nxt = ports_r;
            `RPM_OFF_SFR_MISC: prdata_nxt = misc_r;
            `RPM_OFF_SERIAL_BUF: prdata_nxt = serial_buf_r;
            `RPM_OFF_STATUS: prdata_nxt = {26'h0, sys_rst_r, rst_clean_r, per_en_r, osc_en_r, core_en_r,
                                           pm_r == PM_IDLE};
            default: pslverr_nxt = 1'b1;
         endcase
         if (!rd_acc) begin
            prdata_nxt = 32'h00000000;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
         pready_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         pready_r <= pready_nxt;
      end
   end

   // ==========================================================
   // Outputs straight from flops
   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_core_clk_en = core_en_r;
   assign o_periph_clk_en = per_en_r;
   assign o_osc_en = osc_en_r;
   assign o_sys_reset = sys_rst_r;
   assign o_ports = ports_r;
   assign o_stack_ptr = sp_r;

endmodule

/* hw/rpm_consts.svh */
`ifndef RPM_CONSTS_SVH
`define RPM_CONSTS_SVH
// Register byte offsets on the APB
`define RPM_OFF_PWR_CTRL 12'h000
`define RPM_OFF_STACK_PTR 12'h004
`define RPM_OFF_PORTS 12'h008
`define RPM_OFF_SFR_MISC 12'h00C
`define RPM_OFF_SERIAL_BUF 12'h010
`define RPM_OFF_STATUS 12'h014
`define RPM_OFF_WAKE 12'h018
// Power control field positions
`define RPM_BIT_IDLE 0
`define RPM_BIT_PDOWN 1
`define RPM_BIT_USER_FLAG0 2
`define RPM_BIT_USER_FLAG1 3
`define RPM_BIT_POWER_OFF_FLAG 4
// Reset values
`define RPM_RST_PORTS 32'hFFFFFFFF
`define RPM_RST_SP 8'h07
`define RPM_RST_ZERO 8'h00
// Timing: machine cycle in oscillator periods, sample state and phase, reset hold in machine cycles
`define RPM_OSC_PER_MC 12
`define RPM_SAMPLE_STATE 3'd4
`define RPM_SAMPLE_PHASE 1'b1
`define RPM_RST_HOLD_MC 2
`endif

/* hw/rpm_pkg.sv */
package rpm_pkg;
   typedef enum {PM_RUN, PM_IDLE, PM_PDOWN} pm_state_t;
   typedef struct packed {
      logic [11:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [2:0] state;
      logic phase;
   } mc_pos_t;
endpackage

/* tb/rpm_chk.sv */
`timescale 1ns/100ps
`include "rpm_consts.svh"
// ==========
// Port checker
module rpm_chk #(parameter int HOLD_MC = 2) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ext_reset,
   input wire logic i_irq,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_core_clk_en,
   input wire logic o_periph_clk_en,
   input wire logic o_osc_en,
   input wire logic o_sys_reset,
   input wire logic [31:0] o_ports,
   input wire logic [7:0] o_stack_ptr
);
   logic [7:0] hi_r;
   logic [7:0] hi_nxt;
   // Length of the current high run on the reset pin
   always_comb hi_nxt = !i_ext_reset ? 8'h00 : (hi_r == 8'hFF ? hi_r : hi_r + 8'h01);
   always_ff @(posedge i_clk_sys) hi_r <= hi_nxt;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // Reset loads, clock gating and wake relations
   property p_rst_vals; o_sys_reset [*2] |-> o_ports == 32'hFFFFFFFF && o_stack_ptr == 8'h07; endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset values not held");
   property p_ready_one; o_pready |=> !o_pready; endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready too long");
   property p_idle_periph; o_osc_en |-> o_periph_clk_en; endproperty
   a_idle_periph: assert property (p_idle_periph) else $error("peripheral clock off");
   property p_pdown_all; !o_periph_clk_en |-> !o_core_clk_en && !o_osc_en; endproperty
   a_pdown_all: assert property (p_pdown_all) else $error("clock left running");
   property p_wake; i_irq && o_periph_clk_en && !o_core_clk_en |-> ##[1:2] o_core_clk_en; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_pdown_stay; !o_osc_en && !o_sys_reset |=> !o_osc_en; endproperty
   a_pdown_stay: assert property (p_pdown_stay) else $error("left power-down");
   property p_filter; $rose(o_sys_reset) |-> $past(hi_r, 4) >= 8'(`RPM_OSC_PER_MC); endproperty
   a_filter: assert property (p_filter) else $error("reset from short pulse");
   property p_idle_in;
      i_psel && i_penable && !o_pready && i_pwrite && i_paddr == `RPM_OFF_PWR_CTRL && i_pwdata[1:0] == 2'b01
         && !i_irq |-> ##[1:4] !o_core_clk_en;
   endproperty
   a_idle_in: assert property (p_idle_in) else $error("idle not entered");
   c_idle: cover property (!o_core_clk_en && o_osc_en);
   c_pdown: cover property (!o_osc_en);
   c_ext: cover property ($rose(o_sys_reset));
endmodule

/* tb/rst_line_model.sv */
`timescale 1ns/100ps
// ==========
// External reset network, pulled low when released
module rst_line_model (
   input wire logic i_clk_sys,
   output logic o_line
);
   initial o_line = 1'b0;
   // Hold the line high for n clocks after an edge
   task automatic drive_high(input int n);
      @(posedge i_clk_sys);
      o_line <= 1'b1;
      repeat (n) @(posedge i_clk_sys);
      o_line <= 1'b0;
   endtask
endmodule

/* tb/reset_and_power_mode_control_tb.sv */
`timescale 1ns/100ps
`include "rpm_consts.svh"
// ==========
// Bench top
module reset_and_power_mode_control_tb;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_por = 1'b1;
   logic i_irq = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic i_ext_reset;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h00000000;
   logic [31:0] o_prdata, o_ports, rd;
   logic o_pready, o_pslverr, o_core_clk_en, o_periph_clk_en, o_osc_en, o_sys_reset, err;
   logic [7:0] o_stack_ptr;
   int n_fail = 0;
   int samples_checked = 0;
   reset_and_power_mode_control #(.HOLD_MC(2)) i_reset_and_power_mode_control (.i_clk_sys, .i_rst_n, .i_por,
      .i_ext_reset, .i_irq, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
      .o_core_clk_en, .o_periph_clk_en, .o_osc_en, .o_sys_reset, .o_ports, .o_stack_ptr);
   rst_line_model i_rst_line_model (.i_clk_sys, .o_line(i_ext_reset));
   initial forever #4 i_clk_sys = ~i_clk_sys;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // APB transfer held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         k++;
      end while (o_pready !== 1'b1 && k < 16);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (k >= 16) begin
         n_fail++;
         complete_run();
      end
   endtask
   // Bounded wait on sys_reset (sel 0) or core clock enable
   task automatic wait_for(input int sel, input logic v, input int n);
      int k = 0;
      while (((sel == 0) ? o_sys_reset : o_core_clk_en) !== v && k < n) begin
         @(posedge i_clk_sys);
         k++;
      end
      if (k >= n) begin
         n_fail++;
         complete_run();
      end
   endtask
   task automatic t_reset_vals();
      chk(o_ports, 32'hFFFFFFFF);
      chk({24'h000000, o_stack_ptr}, 32'h00000007);
      apb(1'b0, `RPM_OFF_PWR_CTRL, 32'h00000000);
      chk(rd, 32'h00000010);
      apb(1'b0, `RPM_OFF_SFR_MISC, 32'h00000000);
      chk(rd, 32'h00000000);
      apb(1'b0, `RPM_OFF_WAKE, 32'h00000000);
      chk({31'h00000000, err}, 32'h00000001);
      $display("reset values done");
   endtask
   task automatic t_ext();
      apb(1'b1, `RPM_OFF_STACK_PTR, 32'h0000005A);
      apb(1'b1, `RPM_OFF_PORTS, 32'h12345678);
      apb(1'b1, `RPM_OFF_SFR_MISC, 32'h000000A5);
      apb(1'b1, `RPM_OFF_SERIAL_BUF, 32'h0000003C);
      apb(1'b1, `RPM_OFF_PWR_CTRL, 32'h0000000C);
      apb(1'b0, `RPM_OFF_PWR_CTRL, 32'h00000000);
      chk(rd, 32'h0000000C);
      i_rst_line_model.drive_high(1);
      repeat (60) @(posedge i_clk_sys);
      chk({31'h00000000, o_sys_reset}, 32'h00000000);
      i_rst_line_model.drive_high(72);
      wait_for(0, 1'b0, 40);
      chk(o_ports, 32'hFFFFFFFF);
      chk({24'h000000, o_stack_ptr}, 32'h00000007);
      apb(1'b0, `RPM_OFF_SFR_MISC, 32'h00000000);
      chk(rd, 32'h00000000);
      apb(1'b0, `RPM_OFF_SERIAL_BUF, 32'h00000000);
      chk(rd, 32'h0000003C);
      apb(1'b0, `RPM_OFF_PWR_CTRL, 32'h00000000);
      chk(rd, 32'h00000000);
      $display("external reset done");
   endtask
   task automatic t_idle();
      apb(1'b1, `RPM_OFF_PWR_CTRL, 32'h00000001);
      repeat (4) @(posedge i_clk_sys);
      chk({29'h00000000, o_core_clk_en, o_periph_clk_en, o_osc_en}, 32'h00000003);
      i_irq <= 1'b1;
      wait_for(1, 1'b1, 8);
      i_irq <= 1'b0;
      apb(1'b0, `RPM_OFF_PWR_CTRL, 32'h00000000);
      chk(rd, 32'h00000000);
      $display("idle done");
   endtask
   task automatic t_pdown();
      apb(1'b1, `RPM_OFF_PWR_CTRL, 32'h00000002);
      repeat (4) @(posedge i_clk_sys);
      chk({29'h00000000, o_core_clk_en, o_periph_clk_en, o_osc_en}, 32'h00000000);
      i_irq <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      chk({31'h00000000, o_osc_en}, 32'h00000000);
      i_irq <= 1'b0;
      i_rst_n <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      chk({29'h00000000, o_core_clk_en, o_periph_clk_en, o_osc_en}, 32'h00000007);
      apb(1'b0, `RPM_OFF_PWR_CTRL, 32'h00000000);
      chk(rd, 32'h00000000);
      $display("power-down done");
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      i_por <= 1'b0;
      t_reset_vals();
      t_ext();
      t_idle();
      t_pdown();
      complete_run();
   end
endmodule
bind reset_and_power_mode_control rpm_chk #(.HOLD_MC(HOLD_MC)) i_rpm_chk (.i_clk_sys, .i_rst_n, .i_ext_reset, .i_irq,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_core_clk_en, .o_periph_clk_en, .o_osc_en,
   .o_sys_reset, .o_ports, .o_stack_ptr);
